// file: hdl/dcet_pkg.sv
// Constants, register map and helper functions of the channel event block
`default_nettype none
package dcet_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] DCET_OFS_EVENT_STATUS = 8'h00;
	localparam logic [7:0] DCET_OFS_UPPER_LIMIT  = 8'h04;
	localparam logic [7:0] DCET_OFS_LOWER_LIMIT  = 8'h08;
	localparam logic [7:0] DCET_OFS_CONTROL      = 8'h0c;
	localparam logic [7:0] DCET_OFS_IRQ_STATUS   = 8'h10;
	localparam logic [7:0] DCET_OFS_IRQ_MASK     = 8'h14;

	// ----------------------------------------
	// Event status and control field positions
	// ----------------------------------------
	localparam int DCET_BIT_PENDING  = 15;
	localparam int DCET_SEL_MSB      = 14;
	localparam int DCET_SEL_LSB      = 8;
	localparam int DCET_BIT_HIGH     = 7;
	localparam int DCET_BIT_LOW      = 6;
	localparam int DCET_BIT_DONE     = 5;
	localparam int DCET_BIT_HALF     = 4;
	localparam int DCET_BIT_OVERRUN  = 3;
	localparam int DCET_BIT_HALF_EN  = 0;
	localparam int DCET_BIT_CHAN_ON  = 0;
	localparam int DCET_BIT_DUMMY_WR = 1;

	localparam logic [15:0] DCET_RESET_VALUE  = 16'h0000;
	localparam logic [15:0] DCET_FLAG_MASK    = 16'h00f8;
	localparam logic [15:0] DCET_SFR_TOP      = 16'h07ff;
	localparam logic [15:0] DCET_RAM_TOP_DEF  = 16'h7fff;
	localparam logic [1:0]  DCET_RESP_OKAY    = 2'b00;
	localparam logic [1:0]  DCET_RESP_SLVERR  = 2'b10;

	// ----------------------------------------
	// Trigger selector codes
	// ----------------------------------------
	localparam logic [6:0] DCET_TRIG_EXT_IRQ_ZERO = 7'h00;
	localparam logic [6:0] DCET_TRIG_ECC_SINGLE   = 7'h06;
	localparam logic [6:0] DCET_TRIG_ADC_GROUP    = 7'h27;
	localparam logic [6:0] DCET_TRIG_ADC_AN0      = 7'h28;
	localparam logic [6:0] DCET_TRIG_ADC_AN23     = 7'h3f;

	function automatic logic dcet_code_reserved(input logic [6:0] code);
		dcet_code_reserved = (code == 7'h1a) || (code >= 7'h48 && code <= 7'h56) ||
			(code == 7'h5a) || (code == 7'h5b) || (code == 7'h5e) || (code == 7'h5f) ||
			(code >= 7'h6e);
	endfunction : dcet_code_reserved

	function automatic logic dcet_addr_mapped(input logic [7:0] ofs);
		dcet_addr_mapped = (ofs == DCET_OFS_EVENT_STATUS) || (ofs == DCET_OFS_UPPER_LIMIT) ||
			(ofs == DCET_OFS_LOWER_LIMIT) || (ofs == DCET_OFS_CONTROL) ||
			(ofs == DCET_OFS_IRQ_STATUS) || (ofs == DCET_OFS_IRQ_MASK);
	endfunction : dcet_addr_mapped

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] dcet_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] strb);
		dcet_merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
	endfunction : dcet_merge

endpackage : dcet_pkg
`default_nettype wire

// file: hdl/dcet_trigger_mux.sv
// Trigger selector: picks one peripheral event by code
`timescale 1ns/100ps
`default_nettype none
module dcet_trigger_mux
	import dcet_pkg::*;
(
	input  wire logic [6:0]   trigger_select,
	input  wire logic         external_irq_zero,
	input  wire logic         ecc_single_bit_error,
	input  wire logic         adc_group_done,
	input  wire logic [23:0]  adc_input_done,
	input  wire logic [127:0] other_events,
	output logic              trigger_hit
);
	logic [127:0] events;

	always_comb begin
		events = other_events;
		events[DCET_TRIG_EXT_IRQ_ZERO] = external_irq_zero;
		events[DCET_TRIG_ECC_SINGLE] = ecc_single_bit_error;
		events[DCET_TRIG_ADC_GROUP] = adc_group_done;
		events[DCET_TRIG_ADC_AN23:DCET_TRIG_ADC_AN0] = adc_input_done;
		// Reserved codes never fire, so a bad setting just stalls the channel
		trigger_hit = events[trigger_select] & ~dcet_code_reserved(trigger_select);
	end
endmodule : dcet_trigger_mux
`default_nettype wire

// file: hdl/dcet_axil_slave.sv
// AXI4-Lite slave front end producing register strobes
`timescale 1ns/100ps
`default_nettype none
module dcet_axil_slave
	import dcet_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [15:0]      wr_data,
	output logic [1:0]       wr_strb,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [15:0] rd_data
);
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [15:0] wdata_reg;
	logic [1:0]  wstrb_reg;

	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_en   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign wr_addr = awaddr_reg;
	assign wr_data = wdata_reg;
	assign wr_strb = wstrb_reg;
	assign rd_en   = s_axi_arvalid & s_axi_arready;
	assign rd_addr = s_axi_araddr;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 16'h0000;
			wstrb_reg <= 2'b00;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DCET_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[15:0];
				wstrb_reg <= s_axi_wstrb[1:0];
			end
			if (wr_en) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= dcet_addr_mapped(awaddr_reg) ? DCET_RESP_OKAY : DCET_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= DCET_RESP_OKAY;
		end else if (rd_en) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_data};
			s_axi_rresp <= dcet_addr_mapped(s_axi_araddr) ? DCET_RESP_OKAY : DCET_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : dcet_axil_slave
`default_nettype wire

// file: hdl/dcet_top.sv
// Channel event status, trigger select and interrupt logic of one DMA channel
// What this block does
// - Read-only flag shows buffered word still unstored
// - Seven-bit read/write selector picks trigger event
// - Flag accesses above upper limit or RAM
// - Flag accesses below lower limit above SFRs
// - Limit check follows the access, never precedes
// - Completion flag marks session ended with completion
// - Flag counter reaching half of start count
// - Flag trigger arriving while channel still busy
// - Halfway enable adds interrupt at halfway point
// - Software setting flags raises no interrupt
// - Code 00h selects external interrupt zero
// - Codes 27h-3Fh select converter done events
// - Code 06h selects single-bit memory error
// - Null-write mode adds dummy source write
`timescale 1ns/100ps
`default_nettype none
module dcet_top
	import dcet_pkg::*;
#(
	parameter logic [15:0] DATA_RAM_TOP = DCET_RAM_TOP_DEF
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         external_irq_zero,
	input  wire logic         ecc_single_bit_error,
	input  wire logic         adc_group_done,
	input  wire logic [23:0]  adc_input_done,
	input  wire logic [127:0] other_events,
	input  wire logic         channel_busy,
	input  wire logic         access_done,
	input  wire logic [15:0]  access_addr,
	input  wire logic         counter_step,
	input  wire logic [15:0]  transfer_counter,
	input  wire logic [15:0]  transfer_start_count,
	input  wire logic         session_done,
	input  wire logic         dest_write_done,
	input  wire logic         buffer_loaded,
	input  wire logic         buffer_stored,
	output logic              channel_trigger,
	output logic              dummy_write_request,
	output logic              channel_on,
	output logic              dummy_write_mode,
	output logic              irq
);
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [15:0] wr_data;
	logic [1:0]  wr_strb;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [15:0] rd_data;
	logic        trigger_hit;

	logic [15:0] status_reg;
	logic [15:0] status_next;
	logic [15:0] upper_address_limit_reg;
	logic [15:0] lower_address_limit_reg;
	logic [1:0]  control_reg;
	logic [15:0] irq_status_reg;
	logic [15:0] irq_mask_reg;
	logic        dummy_write_request_reg;
	logic        channel_trigger_reg;

	logic        wr_status;
	logic        rd_irq_status;
	logic        high_hit;
	logic        low_hit;
	logic        half_hit;
	logic [15:0] hw_events;

	// ----------------------------------------
	// Bus slave and trigger selection
	// ----------------------------------------
	dcet_axil_slave u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data)
	);

	dcet_trigger_mux u_mux (
		.trigger_select       (status_reg[DCET_SEL_MSB:DCET_SEL_LSB]),
		.external_irq_zero    (external_irq_zero),
		.ecc_single_bit_error (ecc_single_bit_error),
		.adc_group_done       (adc_group_done),
		.adc_input_done       (adc_input_done),
		.other_events         (other_events),
		.trigger_hit          (trigger_hit)
	);

	// ----------------------------------------
	// Hardware event detection
	// ----------------------------------------
	assign wr_status     = wr_en && (wr_addr == DCET_OFS_EVENT_STATUS);
	assign rd_irq_status = rd_en && (rd_addr == DCET_OFS_IRQ_STATUS);
	assign channel_on       = control_reg[DCET_BIT_CHAN_ON];
	assign dummy_write_mode = control_reg[DCET_BIT_DUMMY_WR];
	assign channel_trigger     = channel_trigger_reg;
	assign dummy_write_request = dummy_write_request_reg;

	// Judged only on a finished access; nothing is screened beforehand
	assign high_hit = access_done &&
		(access_addr > upper_address_limit_reg || access_addr > DATA_RAM_TOP);
	assign low_hit = access_done &&
		(access_addr < lower_address_limit_reg) && (access_addr > DCET_SFR_TOP);
	assign half_hit = counter_step && (transfer_counter == (transfer_start_count >> 1));

	always_comb begin
		hw_events = 16'h0000;
		hw_events[DCET_BIT_HIGH] = high_hit;
		hw_events[DCET_BIT_LOW] = low_hit;
		hw_events[DCET_BIT_DONE] = session_done;
		hw_events[DCET_BIT_HALF] = half_hit;
		hw_events[DCET_BIT_OVERRUN] = trigger_hit && channel_on && channel_busy;
	end

	// ----------------------------------------
	// Event status register
	// ----------------------------------------
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = dcet_merge(status_reg, wr_data, wr_strb);
		end
		status_next = status_next | (hw_events & DCET_FLAG_MASK);
		status_next[2:1] = 2'b00;
		status_next[DCET_BIT_PENDING] = buffer_loaded |
			(status_reg[DCET_BIT_PENDING] & ~buffer_stored);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= DCET_RESET_VALUE;
		end else begin
			status_reg <= status_next;
		end
	end

	// ----------------------------------------
	// Limits and control
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upper_address_limit_reg <= DCET_RESET_VALUE;
			lower_address_limit_reg <= DCET_RESET_VALUE;
			control_reg <= 2'b00;
			irq_mask_reg <= DCET_RESET_VALUE;
		end else if (wr_en) begin
			if (wr_addr == DCET_OFS_UPPER_LIMIT) begin
				upper_address_limit_reg <= dcet_merge(upper_address_limit_reg, wr_data, wr_strb);
			end
			if (wr_addr == DCET_OFS_LOWER_LIMIT) begin
				lower_address_limit_reg <= dcet_merge(lower_address_limit_reg, wr_data, wr_strb);
			end
			if (wr_addr == DCET_OFS_CONTROL && wr_strb[0]) begin
				control_reg <= wr_data[1:0];
			end
			if (wr_addr == DCET_OFS_IRQ_MASK) begin
				irq_mask_reg <= dcet_merge(irq_mask_reg, wr_data, wr_strb) & DCET_FLAG_MASK;
			end
		end
	end

	// ----------------------------------------
	// Datapath strobes
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_trigger_reg <= 1'b0;
			dummy_write_request_reg <= 1'b0;
		end else begin
			channel_trigger_reg <= trigger_hit && channel_on && !channel_busy;
			dummy_write_request_reg <= dest_write_done && dummy_write_mode;
		end
	end

	// ----------------------------------------
	// Interrupt status, read clears
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= DCET_RESET_VALUE;
		end else begin
			// Only hardware events feed it, so flag writes raise nothing; set beats clear
			irq_status_reg <= ((rd_irq_status ? 16'h0000 : irq_status_reg) |
				(hw_events & ~(status_reg[DCET_BIT_HALF_EN] ? 16'h0000 : (16'h0001 << DCET_BIT_HALF)))) &
				DCET_FLAG_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_reg & irq_mask_reg);
		end
	end

	always_comb begin
		case (rd_addr)
			DCET_OFS_EVENT_STATUS: rd_data = status_reg;
			DCET_OFS_UPPER_LIMIT:  rd_data = upper_address_limit_reg;
			DCET_OFS_LOWER_LIMIT:  rd_data = lower_address_limit_reg;
			DCET_OFS_CONTROL:      rd_data = {14'h0, control_reg};
			DCET_OFS_IRQ_STATUS:   rd_data = irq_status_reg;
			DCET_OFS_IRQ_MASK:     rd_data = irq_mask_reg;
			default:               rd_data = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pending_set: assert property (@(posedge aclk) disable iff (!aresetn)
		buffer_loaded |=> status_reg[DCET_BIT_PENDING])
		else $error("pending flag not set after buffer load");
	a_pending_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(buffer_stored && !buffer_loaded) |=> !status_reg[DCET_BIT_PENDING])
		else $error("pending flag not cleared after store");
	a_high_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		(access_done && access_addr > upper_address_limit_reg) |=> status_reg[DCET_BIT_HIGH])
		else $error("high limit flag missed");
	a_low_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		(access_done && access_addr < lower_address_limit_reg && access_addr > DCET_SFR_TOP)
		|=> status_reg[DCET_BIT_LOW])
		else $error("low limit flag missed");
	a_no_precheck: assert property (@(posedge aclk) disable iff (!aresetn)
		(!access_done && !wr_status && !status_reg[DCET_BIT_LOW]) |=> !status_reg[DCET_BIT_LOW])
		else $error("low limit flag without access");
	a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		session_done |=> status_reg[DCET_BIT_DONE] && irq_status_reg[DCET_BIT_DONE])
		else $error("completion not recorded");
	a_half_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(half_hit && !status_reg[DCET_BIT_HALF_EN]) |=> status_reg[DCET_BIT_HALF] &&
		(irq_status_reg[DCET_BIT_HALF] == $past(irq_status_reg[DCET_BIT_HALF]) || $past(rd_irq_status)))
		else $error("halfway interrupt raised while disabled");
	a_overrun_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(trigger_hit && channel_on && channel_busy) |=> status_reg[DCET_BIT_OVERRUN] ##0
		!channel_trigger_reg)
		else $error("overrun not flagged");
	a_sw_no_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_status && hw_events == 16'h0000 && irq_status_reg == 16'h0000) |=>
		irq_status_reg == 16'h0000)
		else $error("software flag write raised interrupt");
	a_dummy_write: assert property (@(posedge aclk) disable iff (!aresetn)
		dummy_write_request_reg |-> $past(dest_write_done) && $past(dummy_write_mode))
		else $error("dummy write without destination write");
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(status_reg[DCET_BIT_DONE] && !wr_status) |=> status_reg[DCET_BIT_DONE])
		else $error("completion flag lost without write");
	a_trigger_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		(trigger_hit && channel_on && !channel_busy) |=> channel_trigger_reg)
		else $error("selected trigger not passed on");
	a_reserved_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		dcet_code_reserved(status_reg[DCET_SEL_MSB:DCET_SEL_LSB]) |=> !channel_trigger_reg)
		else $error("reserved selector code triggered channel");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		irq == $past(|(irq_status_reg & irq_mask_reg)))
		else $error("interrupt level does not follow masked status");
endmodule : dcet_top
`default_nettype wire

// file: verification/dcet_periph_model.sv
// Peripheral event sources and datapath stub facing the channel event block
`timescale 1ns/100ps
`default_nettype none
module dcet_periph_model (
	input  wire logic aclk,
	output logic         external_irq_zero,
	output logic         ecc_single_bit_error,
	output logic         adc_group_done,
	output logic [23:0]  adc_input_done,
	output logic [127:0] other_events,
	output logic         access_done,
	output logic [15:0]  access_addr,
	output logic         counter_step,
	output logic [15:0]  transfer_counter,
	output logic [15:0]  transfer_start_count,
	output logic         session_done,
	output logic         dest_write_done,
	output logic         buffer_loaded,
	output logic         buffer_stored
);
	// ----------------------------------------
	// Idle state
	// ----------------------------------------
	initial begin
		{external_irq_zero, ecc_single_bit_error, adc_group_done, access_done} = '0;
		{counter_step, session_done, dest_write_done, buffer_loaded, buffer_stored} = '0;
		adc_input_done = '0;
		other_events = '0;
		access_addr = 16'h5a5a;
		transfer_counter = 16'h0000;
		transfer_start_count = 16'h0000;
	end

	// ----------------------------------------
	// One-cycle event of kind k
	// ----------------------------------------
	task automatic fire(input int k, input logic [15:0] a, input logic [15:0] c);
		@(posedge aclk);
		case (k)
			0: external_irq_zero <= 1'b1;
			1: ecc_single_bit_error <= 1'b1;
			2: adc_group_done <= 1'b1;
			3: adc_input_done[a[4:0]] <= 1'b1;
			4: begin
				access_done <= 1'b1;
				access_addr <= a;
			end
			5: begin
				counter_step <= 1'b1;
				transfer_start_count <= a;
				transfer_counter <= c;
			end
			6: session_done <= 1'b1;
			7: dest_write_done <= 1'b1;
			8: buffer_loaded <= 1'b1;
			9: buffer_stored <= 1'b1;
			default: other_events[a[6:0]] <= 1'b1;
		endcase
		@(posedge aclk);
		{external_irq_zero, ecc_single_bit_error, adc_group_done, access_done} <= '0;
		{counter_step, session_done, dest_write_done, buffer_loaded, buffer_stored} <= '0;
		adc_input_done <= '0;
		other_events <= '0;
		// Address no longer valid, so never left showing the old value
		if (k == 4)
			access_addr <= ~a;
	endtask : fire
endmodule : dcet_periph_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the channel event block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top
	import dcet_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, channel_busy;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic channel_trigger, dummy_write_request, channel_on, dummy_write_mode;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic external_irq_zero, ecc_single_bit_error, adc_group_done, access_done, counter_step;
	wire logic session_done, dest_write_done, buffer_loaded, buffer_stored;
	wire logic [23:0] adc_input_done;
	wire logic [127:0] other_events;
	wire logic [15:0] access_addr, transfer_counter, transfer_start_count;
	logic [15:0] rv;
	logic [1:0] rr;
	int miscompares, compares;

	dcet_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .external_irq_zero, .ecc_single_bit_error, .adc_group_done, .adc_input_done,
		.other_events, .channel_busy, .access_done, .access_addr, .counter_step, .transfer_counter,
		.transfer_start_count, .session_done, .dest_write_done, .buffer_loaded, .buffer_stored,
		.channel_trigger, .dummy_write_request, .channel_on, .dummy_write_mode, .irq);
	dcet_periph_model pm (.aclk, .external_irq_zero, .ecc_single_bit_error, .adc_group_done,
		.adc_input_done, .other_events, .access_done, .access_addr, .counter_step, .transfer_counter,
		.transfer_start_count, .session_done, .dest_write_done, .buffer_loaded, .buffer_stored);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ----------------------------------------
	// Run control and bus tasks
	// ----------------------------------------
	task automatic final_report;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic guard(inout int n);
		n++;
		if (n > 64) begin
			miscompares++;
			final_report();
		end
	endtask : guard

	// Handshakes are judged at the falling edge, released after the next rising one
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		int n;
		logic da, dw, ta, tw;
		n = 0;
		da = 1'b0;
		dw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awready && !da;
			tw = s_axi_wready && !dw;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
			guard(n);
		end while (!(da && dw));
		do begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge aclk);
			guard(n);
		end while (!ta);
		s_axi_bready <= 1'b0;
		`CHK(rr, DCET_RESP_OKAY)
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		logic t;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
			guard(n);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			rv = s_axi_rdata[15:0];
			rr = s_axi_rresp;
			@(posedge aclk);
			guard(n);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask : rd

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_select;
		logic [6:0] codes [6] = '{7'h00, 7'h06, 7'h27, 7'h28, 7'h3f, 7'h19};
		int kind [6] = '{0, 1, 2, 3, 3, 10};
		logic [15:0] arg [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'd23, 16'h19};
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv, DCET_RESET_VALUE)
		wr(DCET_OFS_CONTROL, 16'h0001);
		`CHK(channel_on, 1'b1)
		foreach (codes[i]) begin
			wr(DCET_OFS_EVENT_STATUS, {1'b0, codes[i], 8'h00});
			rd(DCET_OFS_EVENT_STATUS);
			`CHK(rv[14:8], codes[i])
			pm.fire(kind[i], arg[i], 16'h0000);
			@(negedge aclk);
			`CHK(channel_trigger, 1'b1)
		end
		pm.fire(1, 16'h0, 16'h0);
		@(negedge aclk);
		`CHK(channel_trigger, 1'b0)
		@(posedge aclk);
		channel_busy <= 1'b1;
		pm.fire(10, 16'h19, 16'h0);
		@(negedge aclk);
		`CHK(channel_trigger, 1'b0)
		@(posedge aclk);
		channel_busy <= 1'b0;
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv[7:0], 8'h08)
	endtask : s_select

	task automatic s_limits;
		logic [15:0] up [8] = '{16'hffff, 16'hffff, 16'h2000, 16'h2000, 16'h2000, 16'h2000, 16'h2000, 16'h2000};
		logic [15:0] ad [8] = '{16'h8000, 16'h7fff, 16'h2001, 16'h2000, 16'h0900, 16'h0800, 16'h07ff, 16'h1000};
		logic [7:0] ex [8] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h40, 8'h40, 8'h00, 8'h00};
		wr(DCET_OFS_LOWER_LIMIT, 16'h1000);
		foreach (ad[i]) begin
			wr(DCET_OFS_EVENT_STATUS, 16'h1900);
			wr(DCET_OFS_UPPER_LIMIT, up[i]);
			pm.fire(4, ad[i], 16'h0);
			rd(DCET_OFS_EVENT_STATUS);
			`CHK(rv[7:0], ex[i])
		end
	endtask : s_limits

	task automatic s_irq;
		wr(DCET_OFS_EVENT_STATUS, 16'h1900);
		wr(DCET_OFS_IRQ_MASK, DCET_FLAG_MASK);
		rd(DCET_OFS_IRQ_STATUS);
		pm.fire(5, 16'h0010, 16'h0009);
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv[DCET_BIT_HALF], 1'b0)
		pm.fire(5, 16'h0010, 16'h0008);
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv[DCET_BIT_HALF], 1'b1)
		rd(DCET_OFS_IRQ_STATUS);
		`CHK(rv, 16'h0000)
		`CHK(irq, 1'b0)
		pm.fire(6, 16'h0, 16'h0);
		repeat (2) @(negedge aclk);
		`CHK(irq, 1'b1)
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv[DCET_BIT_DONE], 1'b1)
		rd(DCET_OFS_IRQ_STATUS);
		`CHK(rv, 16'h0020)
		rd(DCET_OFS_IRQ_STATUS);
		@(negedge aclk);
		`CHK(irq, 1'b0)
		wr(DCET_OFS_EVENT_STATUS, 16'h1901);
		pm.fire(5, 16'h0010, 16'h0008);
		rd(DCET_OFS_IRQ_STATUS);
		`CHK(rv, 16'h0010)
		wr(DCET_OFS_EVENT_STATUS, 16'h19f9);
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv, 16'h19f9)
		rd(DCET_OFS_IRQ_STATUS);
		`CHK(rv, 16'h0000)
		`CHK(irq, 1'b0)
		wr(DCET_OFS_EVENT_STATUS, 16'h1900);
	endtask : s_irq

	task automatic s_dummy;
		wr(DCET_OFS_CONTROL, 16'h0003);
		`CHK(dummy_write_mode, 1'b1)
		pm.fire(7, 16'h0, 16'h0);
		@(negedge aclk);
		`CHK(dummy_write_request, 1'b1)
		@(negedge aclk);
		`CHK(dummy_write_request, 1'b0)
		pm.fire(8, 16'h0, 16'h0);
		wr(DCET_OFS_EVENT_STATUS, 16'h1900);
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv[DCET_BIT_PENDING], 1'b1)
		pm.fire(9, 16'h0, 16'h0);
		rd(DCET_OFS_EVENT_STATUS);
		`CHK(rv[DCET_BIT_PENDING], 1'b0)
		wr(DCET_OFS_CONTROL, 16'h0001);
		pm.fire(7, 16'h0, 16'h0);
		@(negedge aclk);
		`CHK(dummy_write_request, 1'b0)
		rd(8'h18);
		`CHK(rr, DCET_RESP_SLVERR)
		`CHK(rv, 16'h0000)
	endtask : s_dummy

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, channel_busy} = '0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h3;
		miscompares = 0;
		compares = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		s_select();
		s_limits();
		s_irq();
		s_dummy();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
